// File: hdl/rail_supervisor_pkg.sv
// Constants shared by the core rail fault supervisor.
package rail_supervisor_pkg;

    // ------------------------------------------------------------------
    // Converter and voltage scaling (levels in 6.25 mV steps; ADC_FULL_UV and ADC_LSB_UV in uV)
    // ------------------------------------------------------------------
    localparam int          CLK_MHZ          = 100;
    localparam int          ADC_BITS         = 9;
    localparam int          ADC_LEVELS       = 511;
    localparam int          ADC_FULL_UV      = 3193750; // 3.19375 V.
    localparam int          ADC_LSB_UV       = 6250;    // 6.25 mV.
    localparam int          VOLT_BITS        = 10;
    localparam logic [9:0]  OFFSET_LEVEL     = 10'h030; // 0.3 V.
    localparam logic [9:0]  OV_FLOOR_LEVEL   = 10'h090; // 0.9 V.
    localparam logic [9:0]  OV_MARGIN        = 10'h034; // 325 mV.
    localparam logic [9:0]  UV_MARGIN        = 10'h050; // 500 mV.
    localparam logic [9:0]  ZERO_LEVEL       = 10'h000; // 0 V.

    // ------------------------------------------------------------------
    // Deglitch times
    // ------------------------------------------------------------------
    localparam int          OV_DELAY_NS      = 1000;
    localparam int          UV_DELAY_NS      = 3000;
    localparam int          UVLO_DELAY_NS    = 3000;
    localparam int          OV_CYCLES        = (OV_DELAY_NS * CLK_MHZ) / 1000;
    localparam int          UV_CYCLES        = (UV_DELAY_NS * CLK_MHZ) / 1000;
    localparam int          UVLO_CYCLES      =
        (UVLO_DELAY_NS * CLK_MHZ) / 1000;
    localparam int          DLY_BITS         = 16;

    // Overcurrent sequencing states.
    typedef enum logic [1:0] {
        OC_IDLE   = 2'b00,
        OC_ACTION = 2'b01,
        OC_SETTLE = 2'b11,
        OC_OFF    = 2'b10
    } oc_state_t;

endpackage : rail_supervisor_pkg

// File: hdl/core_rail_fault_supervisor.sv
// Digital supervision and mode logic for the core rail of a regulator.
`timescale 1ns/1ps
module core_rail_fault_supervisor
    import rail_supervisor_pkg::*;
#(
    parameter int TRIGGER_DELAY = 64,
    parameter int ACTION_DELAY  = 64,
    parameter int SETTLE_DELAY  = 16
) (
    input  wire logic                 clk_i,
    input  wire logic                 reset_i,
    input  wire logic                 enable_i,
    input  wire logic [VOLT_BITS-1:0] core_offset_sense_pin_i,
    input  wire logic                 core_ext_offset_strap_i,
    input  wire logic                 nb_ext_offset_strap_i,
    input  wire logic                 strap_pin_one_i,
    input  wire logic                 strap_pin_two_i,
    input  wire logic                 code_step_up_i,
    input  wire logic                 code_step_down_i,
    input  wire logic                 light_load_i,
    input  wire logic [VOLT_BITS-1:0] current_monitor_pin_i,
    input  wire logic                 fast_load_response_i,
    input  wire logic                 on_time_pulse_i,
    input  wire logic                 cycle_start_i,
    input  wire logic                 above_sustained_i,
    input  wire logic                 above_peak_i,
    input  wire logic [VOLT_BITS-1:0] rail_voltage_sense_i,
    input  wire logic                 rail_voltage_negative_i,
    input  wire logic [VOLT_BITS-1:0] voltage_code_i,
    input  wire logic                 bias_below_por_i,
    input  wire logic                 nb_fault_i,
    output logic                      initial_offset_enable_o,
    output logic                      core_ext_offset_enable_o,
    output logic                      nb_ext_offset_enable_o,
    output logic                      continuous_mode_o,
    output logic [1:0]                slew_comp_bits_o,
    output logic                      ramp_select_o,
    output logic [ADC_BITS-1:0]       reported_current_o,
    output logic                      high_side_on_o,
    output logic                      low_side_on_o,
    output logic                      overcurrent_alert_n_o,
    output logic                      overvoltage_latch_o,
    output logic                      undervoltage_latch_o,
    output logic                      negative_voltage_guard_o,
    output logic                      nb_soft_shutdown_o
);
    import rail_supervisor_pkg::*;

    // ------------------------------------------------------------------
    // Enable edge and strap capture
    // ------------------------------------------------------------------
    logic enable_reg;
    logic enable_rise;
    assign enable_rise = enable_i && !enable_reg;

    // Enable history for edge detection.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            enable_reg <= 1'b0;
        end else begin
            enable_reg <= enable_i;
        end
    end

    // Offset pin and offset straps are looked at only on the enable edge,
    // so later pin movement cannot change the selected mode mid-run.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            initial_offset_enable_o  <= 1'b1;
            core_ext_offset_enable_o <= 1'b0;
            nb_ext_offset_enable_o   <= 1'b0;
        end else if (enable_rise) begin
            initial_offset_enable_o  <=
                (core_offset_sense_pin_i >= OFFSET_LEVEL);
            core_ext_offset_enable_o <= core_ext_offset_strap_i;
            nb_ext_offset_enable_o   <= nb_ext_offset_strap_i;
        end
    end

    // ------------------------------------------------------------------
    // Mode selection
    // ------------------------------------------------------------------
    // Upward steps force continuous mode; a downward step keeps the
    // present mode; otherwise light load allows diode emulation.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            continuous_mode_o <= 1'b1;
        end else if (code_step_up_i) begin
            continuous_mode_o <= 1'b1;
        end else if (!code_step_down_i) begin
            continuous_mode_o <= !light_load_i;
        end
    end

    // Strap decoding is static, registered for clean outputs.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            slew_comp_bits_o <= 2'h0;
            ramp_select_o    <= 1'b0;
        end else begin
            slew_comp_bits_o <= {strap_pin_two_i, strap_pin_one_i};
            ramp_select_o    <= strap_pin_one_i;
        end
    end

    // ------------------------------------------------------------------
    // Current report: input is in 6.25 mV steps; clamp at full scale.
    // ------------------------------------------------------------------
    localparam logic [VOLT_BITS-1:0] ADC_MAX = VOLT_BITS'(ADC_LEVELS);
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            reported_current_o <= 9'h000;
        end else if (current_monitor_pin_i > ADC_MAX) begin
            reported_current_o <= ADC_BITS'(ADC_LEVELS);
        end else begin
            reported_current_o <= current_monitor_pin_i[ADC_BITS-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Overcurrent detection and action sequence
    // ------------------------------------------------------------------
    logic [DLY_BITS-1:0] trig_cnt_reg;
    logic                sustained_overcurrent_trip;
    logic                peak_overcurrent_trip;
    logic                peak_seen_reg;
    oc_state_t           oc_state_reg;
    logic [DLY_BITS-1:0] oc_cnt_reg;
    logic                oc_off_reg;

    assign sustained_overcurrent_trip =
        trig_cnt_reg >= DLY_BITS'(TRIGGER_DELAY);
    assign peak_overcurrent_trip = above_peak_i && !peak_seen_reg;

    // Any dip below threshold restarts the trigger delay.
    always_ff @(posedge clk_i) begin
        if (reset_i || !above_sustained_i) begin
            trig_cnt_reg <= '0;
        end else if (!sustained_overcurrent_trip) begin
            trig_cnt_reg <= trig_cnt_reg + 1'b1;
        end
    end

    // One peak trip per switching cycle.
    always_ff @(posedge clk_i) begin
        if (reset_i || cycle_start_i) begin
            peak_seen_reg <= 1'b0;
        end else if (above_peak_i) begin
            peak_seen_reg <= 1'b1;
        end
    end

    // Action delay, then filter settle, then final current check.
    always_ff @(posedge clk_i) begin
        if (reset_i || enable_rise) begin
            oc_state_reg <= OC_IDLE;
            oc_cnt_reg   <= '0;
        end else begin
            case (oc_state_reg)
                OC_IDLE: begin
                    oc_cnt_reg <= '0;
                    if (sustained_overcurrent_trip ||
                        peak_overcurrent_trip) begin
                        oc_state_reg <= OC_ACTION;
                    end
                end
                OC_ACTION: begin
                    oc_cnt_reg <= oc_cnt_reg + 1'b1;
                    if (oc_cnt_reg == DLY_BITS'(ACTION_DELAY - 1)) begin
                        oc_cnt_reg   <= '0;
                        oc_state_reg <= OC_SETTLE;
                    end
                end
                OC_SETTLE: begin
                    oc_cnt_reg <= oc_cnt_reg + 1'b1;
                    if (oc_cnt_reg == DLY_BITS'(SETTLE_DELAY - 1)) begin
                        oc_cnt_reg   <= '0;
                        oc_state_reg <= (above_sustained_i || above_peak_i)
                                        ? OC_OFF : OC_IDLE;
                    end
                end
                OC_OFF: begin
                    oc_state_reg <= OC_OFF;
                end
                default: begin
                    oc_state_reg <= OC_IDLE;
                end
            endcase
        end
    end

    // Alert follows the trip in the same edge it is seen.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            overcurrent_alert_n_o <= 1'b1;
            oc_off_reg            <= 1'b0;
        end else begin
            overcurrent_alert_n_o <= !(sustained_overcurrent_trip ||
                peak_overcurrent_trip || oc_state_reg != OC_IDLE);
            oc_off_reg <= (oc_state_reg == OC_OFF);
        end
    end

    // ------------------------------------------------------------------
    // Voltage fault deglitch and latches
    // ------------------------------------------------------------------
    logic [VOLT_BITS:0]   ov_limit;
    logic                 ov_cond;
    logic                 uv_cond;
    logic                 por_done_reg;
    logic [DLY_BITS-1:0]  ov_cnt_reg;
    logic [DLY_BITS-1:0]  uv_cnt_reg;
    logic [DLY_BITS-1:0]  uvlo_cnt_reg;
    logic                 uvlo_reg;

    assign ov_limit = (voltage_code_i < OV_FLOOR_LEVEL)
                      ? {1'b0, OV_FLOOR_LEVEL} + {1'b0, OV_MARGIN}
                      : {1'b0, voltage_code_i} + {1'b0, OV_MARGIN};
    assign ov_cond  = por_done_reg &&
        ({1'b0, rail_voltage_sense_i} > ov_limit);
    assign uv_cond  = enable_reg &&
        ({1'b0, rail_voltage_sense_i} + {1'b0, UV_MARGIN} <
         {1'b0, voltage_code_i});

    // Overvoltage monitoring starts on the first edge after power-on reset.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            por_done_reg <= 1'b0;
        end else begin
            por_done_reg <= 1'b1;
        end
    end

    // Persistence counters; any clean sample restarts the count.
    always_ff @(posedge clk_i) begin
        if (reset_i || !ov_cond) begin
            ov_cnt_reg <= '0;
        end else if (ov_cnt_reg < DLY_BITS'(OV_CYCLES)) begin
            ov_cnt_reg <= ov_cnt_reg + 1'b1;
        end
        if (reset_i || !uv_cond) begin
            uv_cnt_reg <= '0;
        end else if (uv_cnt_reg < DLY_BITS'(UV_CYCLES)) begin
            uv_cnt_reg <= uv_cnt_reg + 1'b1;
        end
        if (reset_i || !bias_below_por_i) begin
            uvlo_cnt_reg <= '0;
        end else if (uvlo_cnt_reg < DLY_BITS'(UVLO_CYCLES)) begin
            uvlo_cnt_reg <= uvlo_cnt_reg + 1'b1;
        end
    end

    // Latches hold until reset or a new enable edge; a set on the same
    // edge as the enable edge still wins.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            overvoltage_latch_o  <= 1'b0;
            undervoltage_latch_o <= 1'b0;
            uvlo_reg             <= 1'b0;
        end else begin
            overvoltage_latch_o <= (ov_cnt_reg >= DLY_BITS'(OV_CYCLES)) ||
                (overvoltage_latch_o && !enable_rise);
            undervoltage_latch_o <= (uv_cnt_reg >= DLY_BITS'(UV_CYCLES)) ||
                (undervoltage_latch_o && !enable_rise);
            uvlo_reg <= (uvlo_cnt_reg >= DLY_BITS'(UVLO_CYCLES));
        end
    end

    // Guard only means anything once overvoltage has latched.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            negative_voltage_guard_o <= 1'b0;
        end else begin
            negative_voltage_guard_o <= overvoltage_latch_o &&
                rail_voltage_negative_i;
        end
    end

    // Other rail shuts down on either latch of this rail.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            nb_soft_shutdown_o <= 1'b0;
        end else begin
            nb_soft_shutdown_o <= overvoltage_latch_o ||
                undervoltage_latch_o;
        end
    end

    // ------------------------------------------------------------------
    // Switch drive priority: lockout, undervoltage and overcurrent off,
    // then overvoltage clamp, then disabled or other-rail fault off,
    // then normal pulse with fast response.
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            high_side_on_o <= 1'b0;
            low_side_on_o  <= 1'b0;
        end else if (uvlo_reg) begin
            high_side_on_o <= 1'b0;
            low_side_on_o  <= 1'b0;
        end else if (undervoltage_latch_o || oc_off_reg) begin
            high_side_on_o <= 1'b0;
            low_side_on_o  <= 1'b0;
        end else if (overvoltage_latch_o) begin
            high_side_on_o <= 1'b0;
            low_side_on_o  <= !rail_voltage_negative_i;
        end else if (!enable_reg || nb_fault_i) begin
            high_side_on_o <= 1'b0;
            low_side_on_o  <= 1'b0;
        end else begin
            high_side_on_o <= fast_load_response_i ? 1'b1
                                                   : on_time_pulse_i;
            low_side_on_o  <= !(fast_load_response_i || on_time_pulse_i);
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_ov_low_side: assert property (@(posedge clk_i) disable iff (reset_i)
        overvoltage_latch_o && !uvlo_reg && !undervoltage_latch_o &&
        !oc_off_reg && !rail_voltage_negative_i |=> low_side_on_o &&
        !high_side_on_o) else $error("Clamp missing.");
    chk_nv_off: assert property (@(posedge clk_i) disable iff (reset_i)
        overvoltage_latch_o && rail_voltage_negative_i |=> !low_side_on_o)
        else $error("Negative guard failed.");
    chk_uv_all_off: assert property (@(posedge clk_i) disable iff (reset_i)
        undervoltage_latch_o |=> !high_side_on_o && !low_side_on_o)
        else $error("Undervoltage drive.");
    chk_uvlo_off: assert property (@(posedge clk_i) disable iff (reset_i)
        uvlo_reg |=> !high_side_on_o && !low_side_on_o)
        else $error("Lockout drive.");
    chk_ov_persist: assert property (@(posedge clk_i) disable iff (reset_i)
        $rose(overvoltage_latch_o) |-> $past(ov_cond, OV_CYCLES))
        else $error("Overvoltage latched early.");
    chk_alert_now: assert property (@(posedge clk_i) disable iff (reset_i)
        peak_overcurrent_trip |=> !overcurrent_alert_n_o)
        else $error("Alert late.");
    chk_nv_gate: assert property (@(posedge clk_i) disable iff (reset_i)
        !overvoltage_latch_o |=> !negative_voltage_guard_o)
        else $error("Guard without latch.");
    chk_step_up: assert property (@(posedge clk_i) disable iff (reset_i)
        code_step_up_i |=> continuous_mode_o)
        else $error("No continuous mode.");
    chk_shutdown: assert property (@(posedge clk_i) disable iff (reset_i)
        $rose(undervoltage_latch_o) |=> nb_soft_shutdown_o)
        else $error("Other rail not shut.");

endmodule : core_rail_fault_supervisor

// File: bench/switch_stage_model.sv
// Behavioural model of the switching stage timing seen by the supervisor.
`timescale 1ns/1ps
module switch_stage_model #(
    parameter int PERIOD = 20,
    parameter int ON_LEN = 6
) (
    input  wire logic clk_i,
    input  wire logic reset_i,
    output logic      on_time_pulse_o,
    output logic      cycle_start_o
);
    int count_reg;

    // Free-running cycle counter; each wrap marks a new switching cycle.
    always_ff @(posedge clk_i) begin
        if (reset_i || count_reg == PERIOD - 1) begin
            count_reg <= 0;
        end else begin
            count_reg <= count_reg + 1;
        end
    end

    // Outputs are registered so they move just after an edge, never on it.
    always_ff @(posedge clk_i) begin
        cycle_start_o   <= !reset_i && count_reg == 0;
        on_time_pulse_o <= !reset_i && count_reg < ON_LEN;
    end
endmodule : switch_stage_model

// File: bench/core_rail_fault_supervisor_tb.sv
// Self-checking testbench for the core rail fault supervisor.
`timescale 1ns/1ps
module core_rail_fault_supervisor_tb;
    import rail_supervisor_pkg::*;
    localparam int TRIG = 8;
    localparam int ACT  = 4;
    localparam int SETL = 4;
    logic clk_i = 0, reset_i = 1, enable_i = 0;
    logic [9:0] ofs = 0, current_monitor_pin = 0, rail_voltage_sense = 10'h080, vcode = 10'h080;
    logic cst = 0, nst = 0, s1 = 0, s2 = 0, up = 0, dn = 0, ll = 0;
    logic flr = 0, sus = 0, pk = 0, neg = 0, bias = 0, nbf = 0;
    logic ont, cys, ioe, coe, noe, ccm, rmp, hs, ls, aln, ov, uv, ng, nbs;
    logic [1:0] slew;
    logic [8:0] rep;
    int err_total = 0;
    int checked = 0;

    // ------------------------------------------------------------------
    // Clock, design and partner
    // ------------------------------------------------------------------
    initial begin
        forever #5 clk_i = ~clk_i;
    end

    core_rail_fault_supervisor #(.TRIGGER_DELAY(TRIG), .ACTION_DELAY(ACT),
        .SETTLE_DELAY(SETL)) i_core_rail_fault_supervisor (
        .clk_i(clk_i), .reset_i(reset_i), .enable_i(enable_i),
        .core_offset_sense_pin_i(ofs), .core_ext_offset_strap_i(cst),
        .nb_ext_offset_strap_i(nst), .strap_pin_one_i(s1),
        .strap_pin_two_i(s2), .code_step_up_i(up), .code_step_down_i(dn),
        .light_load_i(ll), .current_monitor_pin_i(current_monitor_pin),
        .fast_load_response_i(flr), .on_time_pulse_i(ont),
        .cycle_start_i(cys), .above_sustained_i(sus), .above_peak_i(pk),
        .rail_voltage_sense_i(rail_voltage_sense), .rail_voltage_negative_i(neg),
        .voltage_code_i(vcode), .bias_below_por_i(bias), .nb_fault_i(nbf),
        .initial_offset_enable_o(ioe), .core_ext_offset_enable_o(coe),
        .nb_ext_offset_enable_o(noe), .continuous_mode_o(ccm),
        .slew_comp_bits_o(slew), .ramp_select_o(rmp),
        .reported_current_o(rep), .high_side_on_o(hs), .low_side_on_o(ls),
        .overcurrent_alert_n_o(aln), .overvoltage_latch_o(ov),
        .undervoltage_latch_o(uv), .negative_voltage_guard_o(ng),
        .nb_soft_shutdown_o(nbs));

    switch_stage_model i_switch_stage_model (.clk_i(clk_i),
        .reset_i(reset_i), .on_time_pulse_o(ont), .cycle_start_o(cys));

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask : cyc

    // Callers sample 1 ns after an edge so the design's updates have landed.
    task automatic chk(input string what, input logic [9:0] exp,
                       input logic [9:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // A fresh enable edge re-samples straps and clears latched faults.
    task automatic re_enable();
        @(posedge clk_i);
        enable_i <= 0;
        cyc(2);
        enable_i <= 1;
        cyc(3);
        #1;
    endtask : re_enable

    task automatic t_straps();
        ofs <= 10'h02f;
        cst <= 1;
        nst <= 1;
        re_enable();
        chk("init_ofs", 0, ioe);
        chk("core_ext", 1, coe);
        chk("nb_ext", 1, noe);
        @(posedge clk_i);
        ofs <= OFFSET_LEVEL;
        cst <= 0;
        nst <= 0;
        re_enable();
        chk("init_ofs", 1, ioe);
        chk("core_ext", 0, coe);
        chk("nb_ext", 0, noe);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_i);
            {s2, s1} <= k[1:0];
            cyc(2);
            #1;
            chk("slew", k[1:0], slew);
            chk("ramp", k[0], rmp);
        end
        $display("test straps done");
    endtask : t_straps

    task automatic t_modes();
        logic [9:0] mon [4] = '{10'h000, 10'h0a5, 10'h1ff, 10'h3ff};
        logic [9:0] exq [4] = '{10'h000, 10'h0a5, 10'h1ff, 10'h1ff};
        @(posedge clk_i);
        ll <= 1;
        cyc(2);
        #1;
        chk("ccm_light", 0, ccm);
        @(posedge clk_i);
        up <= 1;
        cyc(2);
        #1;
        chk("ccm_up", 1, ccm);
        @(posedge clk_i);
        up <= 0;
        dn <= 1;
        cyc(3);
        #1;
        chk("ccm_down", 1, ccm);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_i);
            current_monitor_pin <= mon[k];
            cyc(3);
            #1;
            chk("report", exq[k], rep);
        end
        @(posedge clk_i);
        flr <= 1;
        cyc(2);
        for (int k = 0; k < 25; k++) begin
            @(posedge clk_i);
            #1;
            chk("fast_hs", 1, hs);
            chk("fast_ls", 0, ls);
        end
        @(posedge clk_i);
        flr <= 0;
        $display("test modes done");
    endtask : t_modes

    task automatic t_overcurrent();
        @(posedge clk_i);
        sus <= 1;
        cyc(TRIG - 3);
        sus <= 0;
        cyc(2);
        #1;
        chk("short_sus", 1, aln);
        @(posedge clk_i);
        sus <= 1;
        cyc(TRIG + 4);
        #1;
        chk("sus_alert", 0, aln);
        @(posedge clk_i);
        sus <= 0;
        cyc(ACT + SETL + 2);
        #1;
        chk("oc_recover", 1, aln);
        chk("oc_drive", 1, hs ^ ls);
        re_enable();
        chk("alert_clr", 1, aln);
        @(posedge clk_i);
        pk <= 1;
        cyc(2);
        #1;
        chk("peak_alert", 0, aln);
        cyc(ACT + SETL + 25);
        #1;
        chk("oc_off", 0, {hs, ls});
        @(posedge clk_i);
        pk <= 0;
        re_enable();
        $display("test overcurrent done");
    endtask : t_overcurrent

    task automatic t_overvoltage();
        @(posedge clk_i);
        neg <= 1;
        rail_voltage_sense <= OV_FLOOR_LEVEL + OV_MARGIN;
        cyc(OV_CYCLES + 10);
        #1;
        chk("ov_edge", 0, ov);
        chk("ng_idle", 0, ng);
        @(posedge clk_i);
        neg <= 0;
        rail_voltage_sense <= 10'h0c5;
        cyc(OV_CYCLES - 10);
        #1;
        chk("ov_early", 0, ov);
        cyc(20);
        #1;
        chk("ov_set", 1, ov);
        chk("ov_sw", 1, {hs, ls});
        chk("ov_nb", 1, nbs);
        @(posedge clk_i);
        neg <= 1;
        cyc(3);
        #1;
        chk("nv_guard", 1, ng);
        chk("nv_sw", 0, {hs, ls});
        @(posedge clk_i);
        neg <= 0;
        cyc(3);
        #1;
        chk("nv_back", 1, {hs, ls});
        chk("ov_hold", 1, ov);
        @(posedge clk_i);
        rail_voltage_sense <= 10'h080;
        re_enable();
        chk("ov_clr", 0, ov);
        $display("test overvoltage done");
    endtask : t_overvoltage

    task automatic t_under();
        @(posedge clk_i);
        vcode <= 10'h100;
        rail_voltage_sense <= 10'h100 - UV_MARGIN - 10'h001;
        cyc(UV_CYCLES - 10);
        #1;
        chk("uv_early", 0, uv);
        cyc(20);
        #1;
        chk("uv_set", 1, uv);
        chk("uv_sw", 0, {hs, ls});
        chk("uv_nb", 1, nbs);
        @(posedge clk_i);
        rail_voltage_sense <= 10'h100;
        re_enable();
        chk("uv_clr", 0, uv);
        @(posedge clk_i);
        bias <= 1;
        cyc(UVLO_CYCLES - 10);
        #1;
        chk("uvlo_early", 1, hs ^ ls);
        cyc(20);
        for (int k = 0; k < 20; k++) begin
            @(posedge clk_i);
            #1;
            chk("uvlo_sw", 0, {hs, ls});
        end
        $display("test undervoltage done");
    endtask : t_under

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        cyc(8);
        #1;
        chk("rst_vals", 10'h007, {ov, uv, ioe, ccm, aln});
        @(posedge clk_i);
        reset_i <= 0;
        cyc(1);
        enable_i <= 1;
        cyc(2);
        t_straps();
        t_modes();
        t_overcurrent();
        t_overvoltage();
        t_under();
        tally_and_finish();
    end
endmodule : core_rail_fault_supervisor_tb
